// ---- common/ipf_pkg.sv ----
// Function
// - Code 111 means level 7, highest
// - Code 001 is level 1; codes linear
// - Timer-six field sits in bits 14:12
// - Fields reset to 100, all read/write
// - Code 000 disables its source entirely
//
// Package of the interrupt priority field block: register map,
// field placement, reset and special codes.
// Assumes a single 250 MHz clock domain and a 32-bit register bus.
package ipf_pkg;

    localparam int unsigned IPF_ADDR_W  = 4;     // Byte address width
    localparam int unsigned IPF_DATA_W  = 32;    // Bus data width
    localparam int unsigned IPF_FIELD_W = 3;     // Priority field width
    localparam int unsigned IPF_NUM_SRC = 4;     // Sources held here

    // Register byte offsets
    localparam logic [3:0] IPF_OFF_CTRL10 = 4'h0;
    localparam logic [3:0] IPF_OFF_CTRL11 = 4'h4;

    // Source slots
    localparam int unsigned IPF_SRC_TIMER6 = 0;
    localparam int unsigned IPF_SRC_DMA4   = 1;
    localparam int unsigned IPF_SRC_OC8    = 2;
    localparam int unsigned IPF_SRC_IC6    = 3;

    // Field positions inside their registers
    localparam int unsigned IPF_TIMER6_LSB = 12;
    localparam int unsigned IPF_DMA4_LSB   = 8;
    localparam int unsigned IPF_OC8_LSB    = 0;
    localparam int unsigned IPF_IC6_LSB    = 0;

    // Per-slot register and field position, slot order as above
    localparam logic [3:0] IPF_SRC_OFF [IPF_NUM_SRC] =
        '{IPF_OFF_CTRL11, IPF_OFF_CTRL11, IPF_OFF_CTRL11, IPF_OFF_CTRL10};
    localparam int unsigned IPF_SRC_LSB [IPF_NUM_SRC] =
        '{IPF_TIMER6_LSB, IPF_DMA4_LSB, IPF_OC8_LSB, IPF_IC6_LSB};

    // Field codes
    localparam logic [2:0] IPF_PRIO_RESET = 3'h4;  // Upper bit set
    localparam logic [2:0] IPF_PRIO_OFF   = 3'h0;  // Source disabled
    localparam logic [2:0] IPF_PRIO_MIN   = 3'h1;  // Lowest live level
    localparam logic [2:0] IPF_PRIO_MAX   = 3'h7;  // Highest level

    // Byte lane width
    localparam int unsigned IPF_LANE_W = 8;

endpackage : ipf_pkg

// ---- common/ipf_field_if.sv ----
// Interface between the register front end and one priority field.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface ipf_field_if;
    logic       wr_en;    // One-cycle write strobe
    logic [2:0] wr_data;  // New field code
    logic [2:0] field;    // Held code, from a flop
    logic       enabled;  // Code is not zero, from a flop

    // Field storage end
    modport owner (input wr_en, input wr_data, output field, output enabled);
    // Front end
    modport user (output wr_en, output wr_data, input field, input enabled);
endinterface : ipf_field_if
`default_nettype wire

// ---- logic/ipf_field.sv ----
// One three-bit interrupt priority field with its enable flag.
// Assumes writes arrive as single-cycle strobes on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ipf_field (
    input  wire logic   clk,
    input  wire logic   nrst,
    ipf_field_if.owner  fld
);
    import ipf_pkg::*;

    logic [2:0] field_q;    // Stored code
    logic [2:0] field_d;
    logic       enabled_q;  // Registered non-zero flag
    logic       enabled_d;

    // Next code and enable; enable tracks the next code so both agree
    always_comb begin
        field_d   = field_q;
        if (fld.wr_en) begin
            field_d = fld.wr_data;
        end
        enabled_d = (field_d != IPF_PRIO_OFF);
    end

    // Power-on code is 100 with the source live
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            field_q   <= IPF_PRIO_RESET;
            enabled_q <= 1'b1;
        end else begin
            field_q   <= field_d;
            enabled_q <= enabled_d;
        end
    end

    // Code is the level itself: 001 is 1, 111 is 7
    assign fld.field   = field_q;
    assign fld.enabled = enabled_q;

endmodule : ipf_field
`default_nettype wire

// ---- logic/ipf_top.sv ----
// Priority field registers for timer six, DMA channel four,
// output compare eight and input capture six, on an Avalon-MM slave.
// Assumes source events come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module ipf_top (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire logic [ipf_pkg::IPF_ADDR_W-1:0] avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [ipf_pkg::IPF_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic [ipf_pkg::IPF_DATA_W-1:0]   avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic [ipf_pkg::IPF_NUM_SRC-1:0] src_event,
    output logic [2:0]                       timer_six_priority,
    output logic [2:0]                       dma_channel_four_priority,
    output logic [2:0]                       output_compare_eight_priority,
    output logic [2:0]                       input_capture_six_priority,
    output logic [ipf_pkg::IPF_NUM_SRC-1:0]  src_enabled,
    output logic [ipf_pkg::IPF_NUM_SRC-1:0]  src_request
);
    import ipf_pkg::*;

    // Bus slave state
    logic                    waitreq_q;   // Wait request towards master
    logic                    waitreq_d;
    logic [IPF_DATA_W-1:0]   rdata_q;     // Captured read data
    logic [IPF_DATA_W-1:0]   rdata_d;
    logic                    wr_commit;   // Write takes effect this edge

    // Per-source views
    logic [2:0]              prio_w [IPF_NUM_SRC];  // Field codes
    logic [IPF_NUM_SRC-1:0]  en_w;                  // Field enables
    logic [IPF_NUM_SRC-1:0]  req_q;                 // Gated requests
    logic [IPF_NUM_SRC-1:0]  req_d;

    ipf_field_if fld_if [IPF_NUM_SRC] ();

    // Write lands on the one edge where waitrequest is seen low
    assign wr_commit = avs_write && !waitreq_q;

    // One field per source; each decodes its own register and lane
    for (genvar g = 0; g < IPF_NUM_SRC; g++) begin : g_src
        assign fld_if[g].wr_en   = wr_commit
                                   && (avs_address == IPF_SRC_OFF[g])
                                   && avs_byteenable[IPF_SRC_LSB[g] / IPF_LANE_W];
        assign fld_if[g].wr_data = avs_writedata[IPF_SRC_LSB[g] +: IPF_FIELD_W];
        assign prio_w[g]         = fld_if[g].field;
        assign en_w[g]           = fld_if[g].enabled;

        ipf_field u_field (
            .clk  (clk),
            .nrst (nrst),
            .fld  (fld_if[g])
        );
    end

    // Fixed one wait state: every access completes on its second edge.
    // Readback is built while waiting, so data and the low
    // waitrequest appear together.
    always_comb begin
        waitreq_d = !((avs_read || avs_write) && waitreq_q);
        rdata_d   = rdata_q;
        if (avs_read && waitreq_q) begin
            rdata_d = '0;
            // Unmapped addresses read as zero; only field bits are set
            for (int i = 0; i < IPF_NUM_SRC; i++) begin
                if (avs_address == IPF_SRC_OFF[i]) begin
                    rdata_d[IPF_SRC_LSB[i] +: IPF_FIELD_W] = prio_w[i];
                end
            end
        end
    end

    // Bus slave registers; waitrequest held high through reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            waitreq_q <= 1'b1;
            rdata_q   <= '0;
        end else begin
            waitreq_q <= waitreq_d;
            rdata_q   <= rdata_d;
        end
    end

    // Source events pass only while their field is non-zero
    always_comb begin
        req_d = src_event & en_w;
    end

    // Registered requests to the arbitration logic
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // Outputs, all straight from flops
    assign avs_readdata                  = rdata_q;
    assign avs_waitrequest               = waitreq_q;
    assign timer_six_priority            = prio_w[IPF_SRC_TIMER6];
    assign dma_channel_four_priority     = prio_w[IPF_SRC_DMA4];
    assign output_compare_eight_priority = prio_w[IPF_SRC_OC8];
    assign input_capture_six_priority    = prio_w[IPF_SRC_IC6];
    assign src_enabled                   = en_w;
    assign src_request                   = req_q;

    // Checks below

    // First cycle after reset release, for the reset value check
    logic first_q;
    logic first_d;

    always_comb begin
        first_d = 1'b0;
    end

    // Only this helper reads it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            first_q <= 1'b1;
        end else begin
            first_q <= first_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // A committed write to the second register with full upper lane
    sequence s_wr_ctrl11_hi;
        wr_commit && avs_address == IPF_OFF_CTRL11 && avs_byteenable[1];
    endsequence

    // A read that is answering now
    sequence s_rd_done;
        avs_read && !avs_waitrequest;
    endsequence

    property p_max_level;
        s_wr_ctrl11_hi ##0 (avs_writedata[14:12] == 3'h7)
        |=> timer_six_priority == 3'h7 && src_enabled[IPF_SRC_TIMER6];
    endproperty
    a_max_level: assert property (p_max_level) else $error("code 111 not level 7");

    property p_min_level;
        s_wr_ctrl11_hi ##0 (avs_writedata[10:8] == 3'h1)
        ##1 src_event[IPF_SRC_DMA4]
        |=> dma_channel_four_priority == 3'h1 && src_request[IPF_SRC_DMA4];
    endproperty
    a_min_level: assert property (p_min_level) else $error("code 001 not live level 1");

    property p_timer_bits;
        s_wr_ctrl11_hi |=> timer_six_priority == $past(avs_writedata[14:12]);
    endproperty
    a_timer_bits: assert property (p_timer_bits) else $error("timer field not at 14:12");

    property p_reset_value;
        first_q |-> timer_six_priority == 3'h4 && dma_channel_four_priority == 3'h4
                 && output_compare_eight_priority == 3'h4
                 && input_capture_six_priority == 3'h4;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("field reset not 100");

    property p_disabled;
        input_capture_six_priority == 3'h0 ##1 input_capture_six_priority == 3'h0
        |-> !src_request[IPF_SRC_IC6] && !src_enabled[IPF_SRC_IC6];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled source requested");

    property p_unused_zero;
        s_rd_done |-> avs_readdata[31:15] == '0 && avs_readdata[11] == 1'b0
                   && avs_readdata[7:3] == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits read non-zero");

    property p_readback;
        avs_read && avs_waitrequest && avs_address == IPF_OFF_CTRL11
        |=> avs_readdata[14:12] == timer_six_priority
            && avs_readdata[2:0] == output_compare_eight_priority;
    endproperty
    a_readback: assert property (p_readback) else $error("readback wrong");

    // A committed write to the second register, any lanes
    sequence s_wr_ctrl11;
        wr_commit && avs_address == IPF_OFF_CTRL11;
    endsequence

    // A committed write that hits no register at all
    sequence s_wr_unmapped;
        wr_commit && avs_address != IPF_OFF_CTRL10 && avs_address != IPF_OFF_CTRL11;
    endsequence

    // A request still waiting for its answer
    sequence s_req_waiting;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    // Upper lane off: timer and DMA codes keep their values
    property p_lane_upper;
        s_wr_ctrl11 ##0 !avs_byteenable[1]
        |=> $stable(timer_six_priority) && $stable(dma_channel_four_priority);
    endproperty
    a_lane_upper: assert property (p_lane_upper) else $error("upper lane off but field changed");

    // Lower lane off: compare code keeps its value
    property p_lane_lower;
        s_wr_ctrl11 ##0 !avs_byteenable[0] |=> $stable(output_compare_eight_priority);
    endproperty
    a_lane_lower: assert property (p_lane_lower) else $error("lower lane off but field changed");

    // Writes into holes of the map touch no field
    property p_unmapped_write;
        s_wr_unmapped |=> $stable(timer_six_priority) && $stable(dma_channel_four_priority)
                       && $stable(output_compare_eight_priority) && $stable(input_capture_six_priority);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed a field");

    // First register shows only the capture code, rest zero
    property p_ctrl10_readback;
        avs_read && avs_waitrequest && avs_address == IPF_OFF_CTRL10
        |=> avs_readdata == {29'h0, input_capture_six_priority};
    endproperty
    a_ctrl10_readback: assert property (p_ctrl10_readback) else $error("first register readback wrong");

    // Exactly one wait cycle, then waitrequest rises again
    property p_one_wait;
        s_req_waiting |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");

    // Requests are last edge's events gated by last edge's enables
    property p_request_gate;
        1'b1 |=> src_request == ($past(src_event) & $past(src_enabled));
    endproperty
    a_request_gate: assert property (p_request_gate) else $error("request not gated by enable");

endmodule : ipf_top
`default_nettype wire

// ---- dv/ipf_top_test.sv ----
// Self-checking bench for the priority field block: register bus, field ports, requests.
// Assumes the package, interface and design files are compiled before it.
`timescale 1ns/1ns
`default_nettype none
module ipf_top_test;
    import ipf_pkg::*;

    logic        clk            = 1'b0;   // 250 MHz system clock
    logic        nrst           = 1'b0;   // Async reset, active low
    logic [3:0]  avs_address    = 4'h0;   // Byte address
    logic        avs_read       = 1'b0;   // Read request
    logic        avs_write      = 1'b0;   // Write request
    logic [31:0] avs_writedata  = 32'h0;  // Write word
    logic [3:0]  avs_byteenable = 4'h0;   // Lane enables
    logic [3:0]  src_event      = 4'h0;   // Source event levels
    logic [31:0] avs_readdata;            // Read word
    logic        avs_waitrequest;         // Bus stall
    logic [2:0]  timer_six_priority;      // Field outputs
    logic [2:0]  dma_channel_four_priority;
    logic [2:0]  output_compare_eight_priority;
    logic [2:0]  input_capture_six_priority;
    logic [3:0]  src_enabled;             // Field not zero
    logic [3:0]  src_request;             // Gated events
    logic [31:0] exp_q [$];               // Expected read words, oldest first
    int          failures  = 0;           // Mismatch count
    int          cmp_count = 0;           // Comparison count
    int          seed      = 74929;       // Fixed random seed
    logic [31:0] d;                       // Scratch random word
    logic [3:0]  prev;                    // Events sampled at the last edge
    logic [2:0]  k;                       // Code under test

    // Free-running clock, 4 ns period
    always #2 clk = ~clk;

    ipf_top i_dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .src_event(src_event),
        .timer_six_priority(timer_six_priority), .dma_channel_four_priority(dma_channel_four_priority),
        .output_compare_eight_priority(output_compare_eight_priority),
        .input_capture_six_priority(input_capture_six_priority),
        .src_enabled(src_enabled), .src_request(src_request));

    // Single place where the run ends
    task automatic test_done();
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done

    // Read word against its note
    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected read word at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_rd

    // Port value against expectation
    task automatic cmp_port(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected port value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp_port

    // One bus access; request held until waitrequest is sampled low, bounded wait
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= wd;
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 16);
        if (avs_waitrequest !== 1'b0) begin
            failures++;
            $display("unexpected bus hang at %0t", $time);
            test_done();
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic wr(input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be);
        bus(1'b1, a, wd, be);
    endtask : wr

    // Note the expected word first, the monitor checks it
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    // Fields in order timer, dma, compare, capture; enables follow nonzero codes
    task automatic chk(input logic [11:0] f);
        #1;
        cmp_port({20'h0, timer_six_priority, dma_channel_four_priority, output_compare_eight_priority,
                  input_capture_six_priority}, {20'h0, f});
        cmp_port({28'h0, src_enabled}, {28'h0, f[2:0] != 3'h0, f[5:3] != 3'h0, f[8:6] != 3'h0,
                  f[11:9] != 3'h0});
    endtask : chk

    // Monitor: completed read takes the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("unexpected read with no note at %0t", $time);
            end else begin
                cmp_rd(avs_readdata, exp_q.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        #200000;
        failures++;
        $display("unexpected timeout at %0t", $time);
        test_done();
    end

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        chk(12'h924);
        rd(4'h0, 32'h4);
        rd(4'h4, 32'h4404);
        // Every code in every field, unused bits written as ones; all events held high
        // so that code 000 must block and codes 001 to 111 must pass
        src_event <= 4'hf;
        for (int c = 0; c < 8; c++) begin
            k = c[2:0];
            wr(4'h4, {16'hffff, 1'b1, k, 1'b1, k, 5'h1f, k}, 4'hf);
            rd(4'h4, {17'h0, k, 1'b0, k, 5'h0, k});
            wr(4'h0, {29'h1fffffff, k}, 4'hf);
            rd(4'h0, {29'h0, k});
            chk({k, k, k, k});
            cmp_port({28'h0, src_request}, {28'h0, {4{k != 3'h0}}});
        end
        src_event <= 4'h0;
        // Lane gating leaves other fields alone
        wr(4'h4, 32'h0, 4'h1);
        rd(4'h4, 32'h7700);
        wr(4'h4, 32'h1200, 4'h2);
        rd(4'h4, 32'h1200);
        chk({3'h1, 3'h2, 3'h0, 3'h7});
        // Unmapped places read zero and swallow writes
        wr(4'h8, 32'hffffffff, 4'hf);
        rd(4'h8, 32'h0);
        rd(4'hc, 32'h0);
        rd(4'h4, 32'h1200);
        // Random words land in their field positions
        repeat (8) begin
            d = $random(seed);
            wr(4'h4, d, 4'hf);
            rd(4'h4, d & 32'h7707);
            chk({d[14:12], d[10:8], d[2:0], 3'h7});
        end
        // Disabled sources never request; enable pattern 1010
        wr(4'h4, 32'h0700, 4'hf);
        wr(4'h0, 32'h5, 4'hf);
        chk({3'h0, 3'h7, 3'h0, 3'h5});
        prev = 4'h0;
        repeat (40) begin
            @(posedge clk);
            d = $random(seed);
            src_event <= d[3:0];
            #1;
            cmp_port({28'h0, src_request}, {28'h0, prev & 4'b1010});
            prev = d[3:0];
        end
        // Second reset mid-run restores every field
        @(posedge clk);
        nrst      <= 1'b0;
        src_event <= 4'h0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk(12'h924);
        rd(4'h4, 32'h4404);
        test_done();
    end
endmodule : ipf_top_test
`default_nettype wire
